// ==== logic/swm_master.sv ====
// swm_master.sv: single-wire bus master, reset/presence, byte exchange, program pulse
// assumes an external pull-up on the data line, driven open drain via DQ_OE
`timescale 1ns/1ps
`include "swm_defs.svh"
module swm_master #(
	parameter int RST_LOW_CYC = int'(`SWM_MC_UP(`SWM_RST_LOW_MC)),
	parameter int PRES_CYC    = int'(`SWM_MC_DN(`SWM_PRES_MC)),
	parameter int SHORT_CYC   = int'(`SWM_US_DN(`SWM_SHORT_US)),
	parameter int PULSE_CYC   = int'(`SWM_US_DN(`SWM_PULSE_US)),
	parameter int LONG_CYC    = int'(`SWM_MS_DN(`SWM_LONG_MS))
) (
	input  wire logic                   CLK,
	input  wire logic                   RST,
	input  wire logic                   REQ_VALID,
	input  wire logic [1:0]             REQ_OP,
	input  wire logic [7:0]             REQ_DATA,
	input  wire logic [`SWM_MULT_W-1:0] REQ_MULT,
	input  wire logic                   REQ_LONG,
	output logic                        REQ_READY,
	output logic                        DONE,
	output logic [7:0]                  RESP_DATA,
	output logic                        PRESENCE,
	output logic                        SHORT_ERR,
	input  wire logic                   DQ_IN,
	output logic                        DQ_OUT,
	output logic                        DQ_OE,
	output logic                        PROG_N
);
	localparam int SLOT_LOW  = int'(`SWM_NS_UP(`SWM_SLOT_LOW_NS));
	localparam int SLOT_SMP  = int'(`SWM_NS_UP(`SWM_SLOT_SMP_NS));
	localparam int SLOT_DATA = int'(`SWM_NS_UP(`SWM_SLOT_DATA_NS));
	localparam int SLOT_END  = int'(`SWM_NS_UP(`SWM_SLOT_NS));

	swm_pkg::swm_state_t state_r;
	swm_pkg::swm_cnt_t   cnt_r;
	logic [7:0]          sh_r;
	logic [2:0]          bit_idx_r;
	logic                bit_r;
	logic                pres_r;
	logic                prog_seen_r;
	swm_if               pif ();

	// counter reaches its last cycle of a phase of n cycles
	function automatic logic at_end(input swm_pkg::swm_cnt_t c, input int n);
		at_end = (c == swm_pkg::swm_cnt_t'(n - 1));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// operation sequencer
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= swm_pkg::SWM_IDLE;
			cnt_r   <= '0;
		end else begin
			cnt_r <= cnt_r + swm_pkg::swm_cnt_t'(1);
			case (state_r)
				swm_pkg::SWM_IDLE: begin
					cnt_r <= '0;
					if (REQ_VALID && REQ_READY) begin
						case (REQ_OP)
							`SWM_OP_RESET: state_r <= swm_pkg::SWM_RLOW;
							`SWM_OP_BYTE:  state_r <= swm_pkg::SWM_SLOT;
							`SWM_OP_PROG:  state_r <= swm_pkg::SWM_PROG;
							default:       state_r <= swm_pkg::SWM_IDLE;
						endcase
					end
				end
				swm_pkg::SWM_RLOW: begin
					if (at_end(cnt_r, RST_LOW_CYC)) begin
						state_r <= swm_pkg::SWM_WHIGH;
						cnt_r   <= '0;
					end
				end
				swm_pkg::SWM_WHIGH: begin
					if (DQ_IN) begin
						state_r <= swm_pkg::SWM_PRES;
						cnt_r   <= '0;
					end else if (at_end(cnt_r, SHORT_CYC)) begin
						state_r <= swm_pkg::SWM_IDLE;
					end
				end
				swm_pkg::SWM_PRES: begin
					if (at_end(cnt_r, PRES_CYC)) begin
						state_r <= swm_pkg::SWM_IDLE;
					end
				end
				swm_pkg::SWM_SLOT: begin
					if (at_end(cnt_r, SLOT_END)) begin
						cnt_r <= '0;
						if (bit_idx_r == `SWM_BITS) begin
							state_r <= swm_pkg::SWM_IDLE;
						end
					end
				end
				swm_pkg::SWM_PROG: begin
					if (prog_seen_r && !pif.busy) begin
						state_r <= swm_pkg::SWM_IDLE;
					end
				end
				default: state_r <= swm_pkg::SWM_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// byte shifter: lsb out first, returned bits enter at the top
	always_ff @(posedge CLK) begin
		if (RST) begin
			sh_r      <= 8'h00;
			bit_idx_r <= 3'h0;
			bit_r     <= 1'b1;
		end else if (state_r == swm_pkg::SWM_IDLE) begin
			sh_r      <= REQ_DATA;
			bit_idx_r <= 3'h0;
			bit_r     <= REQ_DATA[0];
		end else if (state_r == swm_pkg::SWM_SLOT) begin
			if (at_end(cnt_r, SLOT_SMP)) begin
				sh_r <= {DQ_IN, sh_r[7:1]};
			end
			if (at_end(cnt_r, SLOT_END)) begin
				bit_idx_r <= bit_idx_r + 3'h1;
				bit_r     <= sh_r[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// line driver: open drain, only ever pulls low
	always_ff @(posedge CLK) begin
		if (RST) begin
			DQ_OE  <= 1'b0;
			DQ_OUT <= 1'b0;
		end else begin
			DQ_OUT <= 1'b0;
			case (state_r)
				swm_pkg::SWM_RLOW: DQ_OE <= 1'b1;
				swm_pkg::SWM_SLOT: DQ_OE <= (cnt_r < swm_pkg::swm_cnt_t'(SLOT_LOW))
					|| (!bit_r && cnt_r < swm_pkg::swm_cnt_t'(SLOT_DATA));
				default:           DQ_OE <= 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// presence capture and completion reporting
	always_ff @(posedge CLK) begin
		if (RST) begin
			pres_r    <= 1'b0;
			PRESENCE  <= 1'b0;
			SHORT_ERR <= 1'b0;
			RESP_DATA <= 8'h00;
			DONE      <= 1'b0;
		end else begin
			DONE <= 1'b0;
			case (state_r)
				swm_pkg::SWM_RLOW: pres_r <= 1'b0;
				swm_pkg::SWM_WHIGH: begin
					if (!DQ_IN && at_end(cnt_r, SHORT_CYC)) begin
						PRESENCE  <= 1'b0;
						SHORT_ERR <= 1'b1;
						DONE      <= 1'b1;
					end
				end
				swm_pkg::SWM_PRES: begin
					pres_r <= pres_r | !DQ_IN;
					if (at_end(cnt_r, PRES_CYC)) begin
						PRESENCE  <= pres_r | !DQ_IN;
						SHORT_ERR <= 1'b0;
						DONE      <= 1'b1;
					end
				end
				swm_pkg::SWM_SLOT: begin
					if (at_end(cnt_r, SLOT_END) && bit_idx_r == `SWM_BITS) begin
						RESP_DATA <= sh_r;
						DONE      <= 1'b1;
					end
				end
				swm_pkg::SWM_PROG: begin
					if (prog_seen_r && !pif.busy) begin
						DONE <= 1'b1;
					end
				end
				default: pres_r <= pres_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// request handshake and pulse generator control
	always_ff @(posedge CLK) begin
		if (RST) begin
			REQ_READY    <= 1'b0;
			pif.start    <= 1'b0;
			pif.long_sel <= 1'b0;
			pif.mult     <= '0;
			prog_seen_r  <= 1'b0;
		end else begin
			REQ_READY <= (state_r == swm_pkg::SWM_IDLE) && !(REQ_VALID && REQ_READY) && !DONE;
			pif.start <= (state_r == swm_pkg::SWM_IDLE) && REQ_VALID && REQ_READY && REQ_OP == `SWM_OP_PROG;
			if (state_r == swm_pkg::SWM_IDLE) begin
				pif.long_sel <= REQ_LONG;
				pif.mult     <= REQ_MULT;
				prog_seen_r  <= 1'b0;
			end else if (pif.busy) begin
				prog_seen_r <= 1'b1;
			end
		end
	end

	// program pin comes straight from the generator's flip-flop
	assign PROG_N = pif.prog_n;

	swm_pulse #(
		.PULSE_CYC (PULSE_CYC),
		.LONG_CYC  (LONG_CYC)
	) u_pulse (
		.CLK (CLK),
		.RST (RST),
		.pif (pif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_slot_start;
		state_r == swm_pkg::SWM_SLOT && cnt_r == '0;
	endsequence

	property p_rst_low;
		state_r == swm_pkg::SWM_RLOW |=> DQ_OE;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("line not low in bus reset");

	property p_short;
		state_r == swm_pkg::SWM_WHIGH && !DQ_IN && at_end(cnt_r, SHORT_CYC)
		|=> DONE && SHORT_ERR && !PRESENCE && state_r == swm_pkg::SWM_IDLE;
	endproperty
	a_short: assert property (p_short) else $error("short circuit not reported");

	property p_pres_catch;
		state_r == swm_pkg::SWM_PRES && !DQ_IN |=> pres_r || state_r == swm_pkg::SWM_IDLE;
	endproperty
	a_pres_catch: assert property (p_pres_catch) else $error("presence low missed");

	property p_pres_report;
		state_r == swm_pkg::SWM_PRES && at_end(cnt_r, PRES_CYC) |=> DONE && PRESENCE == ($past(pres_r) | !$past(DQ_IN));
	endproperty
	a_pres_report: assert property (p_pres_report) else $error("presence flag wrong");

	property p_slot_low;
		s_slot_start |=> DQ_OE [*2];
	endproperty
	a_slot_low: assert property (p_slot_low) else $error("slot did not start low");

	property p_resp;
		state_r == swm_pkg::SWM_SLOT && bit_idx_r == `SWM_BITS && at_end(cnt_r, SLOT_SMP)
		|=> sh_r[7] == $past(DQ_IN);
	endproperty
	a_resp: assert property (p_resp) else $error("returned bit not at top");

	property p_release;
		state_r == swm_pkg::SWM_IDLE |=> !DQ_OE;
	endproperty
	a_release: assert property (p_release) else $error("line held while idle");

	property p_one_req;
		REQ_VALID && REQ_READY |=> !REQ_READY;
	endproperty
	a_one_req: assert property (p_one_req) else $error("second request taken while busy");

	property p_byte_done;
		state_r == swm_pkg::SWM_SLOT && bit_idx_r == `SWM_BITS && at_end(cnt_r, SLOT_END)
		|=> DONE && RESP_DATA == $past(sh_r);
	endproperty
	a_byte_done: assert property (p_byte_done) else $error("byte result not delivered");
endmodule // swm_master

// ==== logic/swm_defs.svh ====
// swm_defs.svh: timing constants of the single-wire bus master
// assumes a 100 MHz system clock; counts derive from printed times
`ifndef SWM_DEFS_SVH
`define SWM_DEFS_SVH

// system clock and the reference crystal whose machine cycles set the reset low and presence times
`define SWM_CLK_HZ        64'd100000000
`define SWM_XTAL_HZ       64'd11059200
`define SWM_MC_CLKS       64'd12

// bus reset timing
`define SWM_RST_LOW_MC    64'd442
`define SWM_PRES_MC       64'd222
`define SWM_SHORT_US      64'd3360

// bit slot timing in ns
`define SWM_SLOT_LOW_NS   64'd1000
`define SWM_SLOT_SMP_NS   64'd13000
`define SWM_SLOT_DATA_NS  64'd61000
`define SWM_SLOT_NS       64'd65000

// programming pulse timing
`define SWM_PULSE_US      64'd500
`define SWM_LONG_MS       64'd2000

// conversions: least times round up, longest times round down
`define SWM_MC_UP(n)      (((n) * `SWM_MC_CLKS * `SWM_CLK_HZ + `SWM_XTAL_HZ - 64'd1) / `SWM_XTAL_HZ)
`define SWM_MC_DN(n)      (((n) * `SWM_MC_CLKS * `SWM_CLK_HZ) / `SWM_XTAL_HZ)
`define SWM_NS_UP(n)      (((n) * `SWM_CLK_HZ + 64'd999999999) / 64'd1000000000)
`define SWM_US_DN(n)      (((n) * `SWM_CLK_HZ) / 64'd1000000)
`define SWM_MS_DN(n)      (((n) * `SWM_CLK_HZ) / 64'd1000)

// operation codes on the request port
`define SWM_OP_RESET      2'h0
`define SWM_OP_BYTE       2'h1
`define SWM_OP_PROG       2'h2

`define SWM_BITS          3'h7
`define SWM_CNT_W         32
`define SWM_MULT_W        8

`endif

// ==== logic/swm_pkg.sv ====
// swm_pkg.sv: types of the single-wire bus master
// assumes swm_defs.svh is on the include path
`include "swm_defs.svh"
package swm_pkg;
	typedef enum logic [2:0] {
		SWM_IDLE  = 3'h0,
		SWM_RLOW  = 3'h1,
		SWM_WHIGH = 3'h2,
		SWM_PRES  = 3'h3,
		SWM_SLOT  = 3'h4,
		SWM_PROG  = 3'h5
	} swm_state_t;
	typedef logic [`SWM_CNT_W-1:0] swm_cnt_t;
endpackage

// ==== logic/swm_if.sv ====
// swm_if.sv: link between the sequencer and the programming pulse generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "swm_defs.svh"
interface swm_if;
	logic                   start;
	logic                   long_sel;
	logic [`SWM_MULT_W-1:0] mult;
	logic                   busy;
	logic                   prog_n;
	modport seq (output start, output long_sel, output mult, input busy, input prog_n);
	modport gen (input start, input long_sel, input mult, output busy, output prog_n);
endinterface

// ==== logic/swm_pulse.sv ====
// swm_pulse.sv: timed low pulse on the program pin
// assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps
`include "swm_defs.svh"
module swm_pulse #(
	parameter int PULSE_CYC = int'(`SWM_US_DN(`SWM_PULSE_US)),
	parameter int LONG_CYC  = int'(`SWM_MS_DN(`SWM_LONG_MS))
) (
	input wire logic CLK,
	input wire logic RST,
	swm_if.gen       pif
);
	logic [39:0] acc_r;
	logic [39:0] tgt_r;
	logic [7:0]  step_r;

	// total work scaled by the clock multiple; progress also scales, so length is fixed
	function automatic logic [39:0] scaled(input logic [31:0] cyc, input logic [7:0] m);
		scaled = 40'(cyc) * 40'(m);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pulse engine
	always_ff @(posedge CLK) begin
		if (RST) begin
			acc_r      <= 40'h0;
			tgt_r      <= 40'h0;
			step_r     <= 8'h1;
			pif.busy   <= 1'b0;
			pif.prog_n <= 1'b1;
		end else if (pif.start && !pif.busy) begin
			acc_r      <= 40'h0;
			step_r     <= (pif.mult == 8'h0) ? 8'h1 : pif.mult;
			tgt_r      <= scaled(pif.long_sel ? 32'(LONG_CYC) : 32'(PULSE_CYC),
				(pif.mult == 8'h0) ? 8'h1 : pif.mult);
			pif.busy   <= 1'b1;
			pif.prog_n <= 1'b0;
		end else if (pif.busy) begin
			acc_r <= acc_r + 40'(step_r);
			if (acc_r + 40'(step_r) >= tgt_r) begin
				pif.busy   <= 1'b0;
				pif.prog_n <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_prog_low;
		@(posedge CLK) disable iff (RST) pif.busy |-> !pif.prog_n;
	endproperty
	a_prog_low: assert property (p_prog_low) else $error("program pin high while pulse runs");

	property p_prog_len;
		@(posedge CLK) disable iff (RST)
		$rose(pif.busy) && tgt_r == scaled(32'(PULSE_CYC), step_r) |-> !pif.prog_n [*8];
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program pulse ended early");
endmodule // swm_pulse

// ==== tb/swm_slave.sv ====
// swm_slave.sv: behavioural memory token on the single-wire bus
// assumes a pull-up on the line and mode hints from the bench
`timescale 1ns/1ps
module swm_slave (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       dq_oe,
	input  wire logic       mode_byte,
	input  wire logic       present,
	input  wire logic       short_en,
	input  wire logic [7:0] rd_byte,
	output logic            dq_lvl,
	output logic [7:0]      wr_byte
);
	logic       oe_q;
	logic [2:0] bit_idx;
	int         run;
	int         pcnt;
	int         plen;
	logic       pull;

	////////////////////////////////////////////////////////////////////////
	// wired-and: pull-up wins only when nobody pulls low
	assign pull   = (pcnt != 0) && (pcnt <= plen);
	assign dq_lvl = ~(dq_oe | pull | short_en);

	// presence answer after a reset, read bits and write decode in slots
	always @(posedge clk) begin
		oe_q <= dq_oe;
		run <= dq_oe ? run + 1 : 0;
		if (pcnt != 0)
			pcnt <= pcnt - 1;
		if (rst) begin
			pcnt <= 0;
			plen <= 0;
			bit_idx <= 3'h0;
			wr_byte <= 8'h00;
		end else if (!mode_byte) begin
			bit_idx <= 3'h0;
			if (oe_q && !dq_oe && present) begin
				pcnt <= 11; // low from 3 to 11 cycles after release
				plen <= 8;
			end
		end else begin
			if (!oe_q && dq_oe && !rd_byte[bit_idx]) begin
				pcnt <= 2000; // hold low past the master's sample point
				plen <= 2000;
			end
			if (oe_q && !dq_oe) begin
				wr_byte[bit_idx] <= (run < 1000); // short low means a one
				bit_idx <= bit_idx + 3'h1;
			end
		end
	end
endmodule // swm_slave

// ==== tb/testbench.sv ====
// testbench.sv: self-checking bench of the single-wire bus master
// assumes swm_slave as the far side, short timing parameters
`timescale 1ns/1ps
module testbench;
	localparam int RLOW = 40;
	localparam int SHRT = 60;
	localparam int PUL  = 30;
	localparam int LNG  = 50;
	logic       CLK, RST, REQ_VALID, REQ_LONG, REQ_READY, DONE, PRESENCE, SHORT_ERR;
	logic       DQ_IN, DQ_OUT, DQ_OE, PROG_N, mode_byte, present, short_en;
	logic [1:0] REQ_OP;
	logic [7:0] REQ_DATA, REQ_MULT, RESP_DATA, sb, dv, wr_byte;
	logic [7:0] mt [5] = '{8'h00, 8'h01, 8'h06, 8'hFF, 8'h06};
	int         n_errors, total_checks, seed, prog_lo, oe_run, oe_first, min_lo, n_runs, k;

	////////////////////////////////////////////////////////////////////////
	// design and far-side token
	swm_master #(.RST_LOW_CYC(RLOW), .PRES_CYC(20), .SHORT_CYC(SHRT), .PULSE_CYC(PUL),
		.LONG_CYC(LNG)) i_swm_master (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
		.REQ_OP(REQ_OP), .REQ_DATA(REQ_DATA), .REQ_MULT(REQ_MULT), .REQ_LONG(REQ_LONG),
		.REQ_READY(REQ_READY), .DONE(DONE), .RESP_DATA(RESP_DATA), .PRESENCE(PRESENCE),
		.SHORT_ERR(SHORT_ERR), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .PROG_N(PROG_N));
	swm_slave i_swm_slave (.clk(CLK), .rst(RST), .dq_oe(DQ_OE), .mode_byte(mode_byte),
		.present(present), .short_en(short_en), .rd_byte(sb), .dq_lvl(DQ_IN), .wr_byte(wr_byte));

	// 100 MHz clock
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	////////////////////////////////////////////////////////////////////////
	// compare, report and close
	task chk(input bit ok, input string msg);
		total_checks++;
		if (!ok) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask

	task end_sim;
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// hold reset for n edges, check the idle values, then release just after an edge
	task rst_pulse(input int n);
		RST = 1'b1;
		repeat (n) @(posedge CLK);
		#1;
		chk({REQ_READY, DONE, PRESENCE, SHORT_ERR, DQ_OE, DQ_OUT, PROG_N, RESP_DATA} === 15'h0100, "reset values");
		RST = 1'b0;
	endtask

	// bit-serial model of the wired-and exchange, lsb first
	function automatic int model_rx(input int tx, input int rd);
		int r;
		r = 0;
		for (int b = 0; b < 8; b++)
			r = r | ((((tx >> b) & (rd >> b)) & 1) << b);
		return r;
	endfunction

	// one request held until taken, kept up while refused, dropped at done
	task run_op(input logic [1:0] op, input logic [7:0] d, input logic [7:0] m, input logic lg);
		k = 0;
		while (REQ_READY !== 1'b1 && k < 100) begin
			@(posedge CLK);
			#1;
			k++;
		end
		chk(k < 100, "ready not raised");
		chk(DQ_OE === 1'b0 && PROG_N === 1'b1, "pins held while idle");
		prog_lo = 0;
		oe_run = 0;
		oe_first = 0;
		min_lo = 1 << 30;
		n_runs = 0;
		REQ_VALID = 1'b1;
		REQ_OP = op;
		REQ_DATA = d;
		REQ_MULT = m;
		REQ_LONG = lg;
		@(posedge CLK);
		#1;
		k = 0;
		while (DONE !== 1'b1 && k < 60000) begin
			chk(REQ_READY === 1'b0, "ready while busy");
			REQ_DATA = 8'($random(seed));
			@(posedge CLK);
			#1;
			k++;
		end
		REQ_VALID = 1'b0;
		chk(k < 60000, "no completion");
	endtask

	// pulse widths and low runs on the pins
	always @(posedge CLK) begin
		if (PROG_N === 1'b0)
			prog_lo++;
		if (DQ_OE === 1'b1) begin
			oe_run++;
			chk(DQ_OUT === 1'b0, "data line driven high");
		end else if (oe_run > 0) begin
			if (oe_first == 0)
				oe_first = oe_run;
			if (oe_run < min_lo)
				min_lo = oe_run;
			n_runs++;
			oe_run = 0;
		end
	end

	// watchdog: the run needs about 53000 cycles
	initial begin
		#800000;
		n_errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		end_sim;
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 67;
		n_errors = 0;
		total_checks = 0;
		RST = 1'b1;
		REQ_VALID = 1'b0;
		REQ_OP = 2'h0;
		REQ_DATA = 8'h00;
		REQ_MULT = 8'h00;
		REQ_LONG = 1'b0;
		mode_byte = 1'b0;
		present = 1'b0;
		short_en = 1'b0;
		sb = 8'h00;
		rst_pulse(20);
		// bus reset with a token, with none, and against a shorted line
		for (int i = 0; i < 3; i++) begin
			present = (i == 0);
			short_en = (i == 2);
			run_op(2'h0, 8'h00, 8'h00, 1'b0);
			chk(oe_first == RLOW, "reset low length");
			chk(PRESENCE === (i == 0), "presence flag");
			chk(SHORT_ERR === (i == 2), "short flag");
			chk((k >= RLOW + SHRT) == (i == 2), "short timeout");
		end
		short_en = 1'b0;
		present = 1'b0;
		// reset in mid-run must clear the short flag left by the last bus reset
		rst_pulse(2);
		// program pulse over several multiples, then the long mode
		for (int j = 0; j < 5; j++) begin
			run_op(2'h2, 8'h00, mt[j], j == 4);
			chk(prog_lo == ((j == 4) ? LNG : PUL), "program pulse length");
			chk(PROG_N === 1'b1, "program pin not high");
		end
		// byte exchange: upper nibble read slots, lower nibble random writes
		sb = 8'($random(seed));
		dv = {4'hF, 4'($random(seed))};
		mode_byte = 1'b1;
		run_op(2'h1, dv, 8'h00, 1'b0);
		mode_byte = 1'b0;
		chk(RESP_DATA === 8'(model_rx(dv, sb)), "returned byte");
		chk(wr_byte === dv, "bit order on the wire");
		chk(n_runs == 8 && min_lo >= 100, "slot count or slot low");
		end_sim;
	end
endmodule // testbench
